// ---- logic/isx_exec.sv ----
// Decode and execute of increment-skip, the two OR forms and literal load.
// Function
// [RULE1] Increment file, write destination, flags untouched.
// [RULE2] Zero increment result turns next slot idle.
// [RULE3] Destination bit 0 accumulator, 1 file.
// [RULE4] OR accumulator with file, update zero.
// [RULE5] OR literal into accumulator, update zero.
// [RULE6] Load literal into accumulator, flags untouched.
// [RULE7] Load opcode ignores its two don't-care bits.
// [RULE8] Zero flag set exactly when result zero.
// [RULE9] Instruction cycle is four oscillator periods.
// [RULE10] Seven-bit file field addresses 0 to 7f.
`timescale 1ns/100ps
module isx_exec
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [isx_pkg::INSTR_W-1:0] instr_word,
    output logic fetch_stb,
    output logic [isx_pkg::FILE_W-1:0] file_addr,
    input wire logic [isx_pkg::DATA_W-1:0] file_rdata,
    output logic [isx_pkg::DATA_W-1:0] file_wdata,
    output logic file_we,
    output logic [isx_pkg::DATA_W-1:0] acc,
    output logic zero_flag,
    output logic idle_slot,
    output logic decode_hit
);
    import isx_pkg::*;

    isx_phase_if ph ();

    isx_phase u_phase
    (
        .core_clk(core_clk),
        .rst(rst),
        .ph(ph)
    );

    logic [INSTR_W-1:0] ir_r;
    logic [INSTR_W-1:0] ir_nxt;
    logic idle_r;
    logic idle_nxt;
    logic skip_r;
    logic skip_nxt;
    logic [DATA_W-1:0] acc_r;
    logic [DATA_W-1:0] acc_nxt;
    logic zero_r;
    logic zero_nxt;
    logic [FILE_W-1:0] addr_r;
    logic [FILE_W-1:0] addr_nxt;
    logic [DATA_W-1:0] wdata_r;
    logic [DATA_W-1:0] wdata_nxt;
    logic we_r;
    logic we_nxt;
    logic hit_r;
    logic hit_nxt;

    isx_op_t op;
    logic dest;
    logic [DATA_W-1:0] lit;
    logic [DATA_W-1:0] inc_sum;
    logic [DATA_W-1:0] or_file;
    logic [DATA_W-1:0] or_lit;

    // [RULE7] Decode masks don't-care bits.
    assign op = isx_decode(ir_r);
    assign dest = ir_r[DEST_BIT];
    assign lit = ir_r[LIT_LSB +: DATA_W];
    assign inc_sum = file_rdata + 8'h01;
    assign or_file = acc_r | file_rdata;
    assign or_lit = acc_r | lit;

    // Fetch group. The word is taken at the first phase; the file read then has three
    // phases to settle before the result is committed in the last phase.
    always_comb
    begin
        ir_nxt = ir_r;
        idle_nxt = idle_r;
        hit_nxt = hit_r;
        addr_nxt = addr_r;
        if (ph.q1_stb)
        begin
            ir_nxt = instr_word;
            // [RULE2] Prefetched word discarded.
            idle_nxt = skip_r;
            hit_nxt = (isx_decode(instr_word) != OP_NONE) && !skip_r;
            // [RULE10] Seven-bit file address.
            addr_nxt = instr_word[FILE_LSB +: FILE_W];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ir_r <= IR_RESET;
            idle_r <= 1'b0;
            hit_r <= 1'b0;
            addr_r <= '0;
        end
        else
        begin
            ir_r <= ir_nxt;
            idle_r <= idle_nxt;
            hit_r <= hit_nxt;
            addr_r <= addr_nxt;
        end
    end

    // Result group. Nothing commits in an idle slot, so a skipped increment can never
    // arm a second skip.
    always_comb
    begin
        acc_nxt = acc_r;
        zero_nxt = zero_r;
        skip_nxt = skip_r;
        if (ph.q1_stb)
        begin
            // The skip covers only the slot being fetched now.
            skip_nxt = 1'b0;
        end
        else if (ph.q4_stb && !idle_r)
        begin
            unique case (op)
                OP_INC_SKIP:
                begin
                    // [RULE1] Increment, no flag change.
                    // [RULE3] Destination select.
                    if (dest == DEST_ACC)
                    begin
                        acc_nxt = inc_sum;
                    end
                    // [RULE2] Zero result arms skip.
                    skip_nxt = (inc_sum == 8'h00);
                end
                OP_OR_ACC_FILE:
                begin
                    // [RULE4] OR with file register.
                    if (dest == DEST_ACC)
                    begin
                        acc_nxt = or_file;
                    end
                    // [RULE8] Zero from result.
                    zero_nxt = (or_file == 8'h00);
                end
                OP_OR_LIT:
                begin
                    // [RULE5] OR literal into accumulator.
                    acc_nxt = or_lit;
                    // [RULE8] Zero from result.
                    zero_nxt = (or_lit == 8'h00);
                end
                OP_LOAD_LIT:
                begin
                    // [RULE6] Literal load, no flags.
                    acc_nxt = lit;
                end
                OP_NONE:
                begin
                    acc_nxt = acc_r;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            acc_r <= ACC_RESET;
            zero_r <= ZERO_RESET;
            skip_r <= 1'b0;
        end
        else
        begin
            acc_r <= acc_nxt;
            zero_r <= zero_nxt;
            skip_r <= skip_nxt;
        end
    end

    // Write group. The pulse follows the commit phase by one clock, while the file
    // address still holds the field of the instruction that produced the data.
    always_comb
    begin
        wdata_nxt = wdata_r;
        we_nxt = 1'b0;
        // [RULE3] Destination bit selects file.
        if (ph.q4_stb && !idle_r && dest == DEST_FILE)
        begin
            if (op == OP_INC_SKIP)
            begin
                wdata_nxt = inc_sum;
                we_nxt = 1'b1;
            end
            else if (op == OP_OR_ACC_FILE)
            begin
                wdata_nxt = or_file;
                we_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wdata_r <= '0;
            we_r <= 1'b0;
        end
        else
        begin
            wdata_r <= wdata_nxt;
            we_r <= we_nxt;
        end
    end

    assign fetch_stb = ph.q1_stb;
    assign file_addr = addr_r;
    assign file_wdata = wdata_r;
    assign file_we = we_r;
    assign acc = acc_r;
    assign zero_flag = zero_r;
    assign idle_slot = idle_r;
    assign decode_hit = hit_r;
endmodule

// ---- logic/isx_phase.sv ----
// Four-phase instruction cycle sequencer driven by the oscillator clock.
`timescale 1ns/100ps
module isx_phase
(
    input wire logic core_clk,
    input wire logic rst,
    isx_phase_if.gen ph
);
    import isx_pkg::*;

    isx_phase_t phase_r;
    isx_phase_t phase_nxt;

    // [RULE9] Four oscillator phases.
    always_comb
    begin
        unique case (phase_r)
            PH_Q1: phase_nxt = PH_Q2;
            PH_Q2: phase_nxt = PH_Q3;
            PH_Q3: phase_nxt = PH_Q4;
            PH_Q4: phase_nxt = PH_Q1;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            phase_r <= PH_Q1;
        else
            phase_r <= phase_nxt;
    end

    assign ph.q1_stb = (phase_r == PH_Q1);
    assign ph.q4_stb = (phase_r == PH_Q4);
    assign ph.phase = phase_r;
endmodule

// ---- pkg/isx_phase_if.sv ----
// Phase strobes passed from the cycle sequencer to the executor.
`timescale 1ns/100ps
interface isx_phase_if;
    logic q1_stb;
    logic q4_stb;
    isx_pkg::isx_phase_t phase;

    modport gen
    (
        output q1_stb,
        output q4_stb,
        output phase
    );

    modport use_side
    (
        input q1_stb,
        input q4_stb,
        input phase
    );
endinterface

// ---- pkg/isx_pkg.sv ----
// Opcode patterns, field positions and timing constants for the instruction executor.
package isx_pkg;

    // Instruction word and field layout.
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FILE_W = 7;
    localparam int FILE_LSB = 0;
    localparam int LIT_LSB = 0;
    localparam int DEST_BIT = 7;
    localparam logic [FILE_W-1:0] FILE_ADDR_MAX = 7'h7f;

    // Destination select values.
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // Opcode match masks and values.
    localparam logic [INSTR_W-1:0] OPC_MASK_FULL = 14'h3f00;
    localparam logic [INSTR_W-1:0] OPC_MASK_LOAD = 14'h3c00;
    localparam logic [INSTR_W-1:0] OPC_INC_SKIP = 14'h0f00;
    localparam logic [INSTR_W-1:0] OPC_OR_ACC_FILE = 14'h0400;
    localparam logic [INSTR_W-1:0] OPC_OR_LIT = 14'h3800;
    localparam logic [INSTR_W-1:0] OPC_LOAD_LIT = 14'h3000;

    // Oscillator periods per instruction cycle.
    localparam int OSC_PER_CYCLE = 4;

    // Reset values.
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;
    localparam logic [INSTR_W-1:0] IR_RESET = 14'h0000;

    typedef enum logic [2:0]
    {
        OP_NONE = 3'h0,
        OP_INC_SKIP = 3'h1,
        OP_OR_ACC_FILE = 3'h2,
        OP_OR_LIT = 3'h3,
        OP_LOAD_LIT = 3'h4
    } isx_op_t;

    // Quarter-cycle phases in Gray order.
    typedef enum logic [1:0]
    {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b11,
        PH_Q4 = 2'b10
    } isx_phase_t;

    function automatic isx_op_t isx_decode(input logic [INSTR_W-1:0] word);
        isx_op_t op;
        op = OP_NONE;
        if ((word & OPC_MASK_FULL) == OPC_INC_SKIP)
            op = OP_INC_SKIP;
        else if ((word & OPC_MASK_FULL) == OPC_OR_ACC_FILE)
            op = OP_OR_ACC_FILE;
        else if ((word & OPC_MASK_FULL) == OPC_OR_LIT)
            op = OP_OR_LIT;
        else if ((word & OPC_MASK_LOAD) == OPC_LOAD_LIT)
            op = OP_LOAD_LIT;
        return op;
    endfunction

endpackage

// ---- sim/isx_exec_chk.sv ----
// Concurrent checks on the executor ports.
`timescale 1ns/100ps
module isx_exec_chk
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [isx_pkg::INSTR_W-1:0] instr_word,
    input wire logic fetch_stb,
    input wire logic [isx_pkg::DATA_W-1:0] file_wdata,
    input wire logic file_we,
    input wire logic [isx_pkg::DATA_W-1:0] acc,
    input wire logic zero_flag,
    input wire logic idle_slot,
    input wire logic decode_hit
);
    import isx_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_fetch; fetch_stb |=> !fetch_stb [*3] ##1 fetch_stb; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch spacing");
    property p_we; file_we |-> fetch_stb ##1 !file_we; endproperty
    a_we: assert property (p_we) else $error("write pulse");
    property p_acc_slot; $changed(acc) |-> fetch_stb; endproperty
    a_acc_slot: assert property (p_acc_slot) else $error("acc timing");
    property p_zero_slot; $changed(zero_flag) |-> fetch_stb; endproperty
    a_zero_slot: assert property (p_zero_slot) else $error("zero timing");
    property p_zero_val; $rose(zero_flag) |-> acc == 8'h00 || file_wdata == 8'h00; endproperty
    a_zero_val: assert property (p_zero_val) else $error("zero value");
    property p_idle_len; $rose(idle_slot) |-> idle_slot [*4] ##1 !idle_slot; endproperty
    a_idle_len: assert property (p_idle_len) else $error("idle length");
    property p_idle_hold;
        idle_slot |-> !file_we && !decode_hit && $stable(acc) && $stable(zero_flag);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("idle activity");
    property p_load;
        fetch_stb && instr_word[13:10] == 4'hc ##1 decode_hit
            |-> ##3 acc == $past(instr_word[7:0], 4);
    endproperty
    a_load: assert property (p_load) else $error("literal load");
    // The four opcode patterns, spare load bits ignored; every other word is refused.
    property p_hit;
        fetch_stb ##1 !idle_slot |-> decode_hit == ($past(instr_word[13:8]) == 6'h0f
            || $past(instr_word[13:8]) == 6'h04 || $past(instr_word[13:8]) == 6'h38
            || $past(instr_word[13:10]) == 4'hc);
    endproperty
    a_hit: assert property (p_hit) else $error("decode hit");
    c_skip: cover property ($rose(idle_slot));
    c_write: cover property (file_we);
    c_zero: cover property ($rose(zero_flag));
endmodule

// ---- sim/isx_mem.sv ----
// Program memory and register file facing the executor.
`timescale 1ns/100ps
module isx_mem
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic fetch_stb,
    input wire logic [isx_pkg::FILE_W-1:0] file_addr,
    input wire logic [isx_pkg::DATA_W-1:0] file_wdata,
    input wire logic file_we,
    output logic [isx_pkg::INSTR_W-1:0] instr_word,
    output logic [isx_pkg::DATA_W-1:0] file_rdata
);
    import isx_pkg::*;
    logic [INSTR_W-1:0] prog [$];
    logic [DATA_W-1:0] rf [128];
    int pc;
    initial instr_word = 14'h0000;
    assign file_rdata = rf[file_addr];
    // Words past the end read as X, which the decoder resolves to no opcode, so the block ignores them.
    always @(posedge core_clk)
    begin
        if (file_we)
            rf[file_addr] <= file_wdata;
        pc <= rst ? 0 : pc + fetch_stb;
        if (rst | fetch_stb)
            instr_word <= prog[rst ? 0 : pc + 1];
    end
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the instruction executor.
`timescale 1ns/100ps
module testbench;
    import isx_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [INSTR_W-1:0] instr_word;
    logic fetch_stb, file_we, zero_flag, idle_slot, decode_hit;
    logic [FILE_W-1:0] file_addr;
    logic [DATA_W-1:0] file_rdata, file_wdata, acc;
    logic [9:0] ex [$];
    int err_count = 0;
    int tests_run = 0;
    initial
    begin
        forever #50 core_clk = ~core_clk;
    end
    isx_exec dut (.core_clk(core_clk), .rst(rst), .instr_word(instr_word),
        .fetch_stb(fetch_stb), .file_addr(file_addr), .file_rdata(file_rdata),
        .file_wdata(file_wdata), .file_we(file_we), .acc(acc),
        .zero_flag(zero_flag), .idle_slot(idle_slot), .decode_hit(decode_hit));
    isx_mem mem (.core_clk(core_clk), .rst(rst), .fetch_stb(fetch_stb),
        .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
        .instr_word(instr_word), .file_rdata(file_rdata));
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Each entry of ex is {idle, zero, acc} seen once its slot has completed.
    task automatic run(input string name);
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        foreach (ex[i])
        begin
            repeat (4) @(negedge core_clk);
            chk({idle_slot, zero_flag, acc}, ex[i]);
        end
        $display("%s done", name);
    endtask
    task automatic t_reset;
        chk({idle_slot, zero_flag, acc}, 10'h000);
        chk({7'h00, file_we, decode_hit, fetch_stb}, 10'h001);
        $display("reset done");
    endtask
    task automatic t_or;
        mem.rf[4] = 8'h04;
        mem.rf[5] = 8'h13;
        mem.rf[6] = 8'h00;
        mem.prog = '{14'h3091, 14'h0405, 14'h0484, 14'h3000, 14'h0406, 14'h389a, 14'h3835,
            14'h3000, 14'h3800, 14'h31a5, 14'h325a, 14'h3300, 14'h0000};
        ex = '{10'h091, 10'h093, 10'h093, 10'h000, 10'h100, 10'h09a, 10'h0bf,
            10'h000, 10'h100, 10'h1a5, 10'h15a, 10'h100, 10'h100};
        run("or_load");
        chk({2'b00, mem.rf[4]}, 10'h097);
    endtask
    // A skipped increment at the top address shows the skipped word never lands.
    task automatic t_inc;
        mem.rf[7] = 8'hfe;
        mem.rf[127] = 8'hff;
        mem.prog = '{14'h3811, 14'h0f87, 14'h0f07, 14'h3022, 14'h3033, 14'h0fff, 14'h0fff,
            14'h3844};
        ex = '{10'h011, 10'h011, 10'h000, 10'h200, 10'h033, 10'h033, 10'h233, 10'h077};
        run("inc_skip");
        chk({2'b00, mem.rf[7]}, 10'h0ff);
        chk({2'b00, mem.rf[127]}, 10'h000);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(negedge core_clk);
        t_reset;
        t_or;
        t_inc;
        summarize;
    end
endmodule
bind isx_exec isx_exec_chk chk (.core_clk(core_clk), .rst(rst), .instr_word(instr_word),
    .fetch_stb(fetch_stb), .file_wdata(file_wdata), .file_we(file_we), .acc(acc),
    .zero_flag(zero_flag), .idle_slot(idle_slot), .decode_hit(decode_hit));
